// >>> verilog/prds_pkg.sv
package prds_pkg;
   ////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the avalon slave
   localparam int         ADDR_W       = 5;
   localparam logic [4:0] OFS_MODE     = 5'h00;
   localparam logic [4:0] OFS_SHUT     = 5'h04;
   localparam logic [4:0] OFS_DLY      = 5'h08;
   localparam logic [4:0] OFS_STEER    = 5'h0c;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
   localparam logic [4:0] OFS_STATUS   = 5'h18;
   ////////////////////////////////////////////////////////////////////
   // values after reset
   localparam logic [5:0] RST_MODE  = 6'h00;
   localparam logic [7:0] RST_SHUT  = 8'h00;
   localparam logic [7:0] RST_DLY   = 8'h00;
   localparam logic [4:0] RST_STEER = 5'h01;
   localparam logic [1:0] RST_IRQ   = 2'h0;
   ////////////////////////////////////////////////////////////////////
   // field codes and positions
   localparam logic [1:0] MODE_PWM   = 2'h3;
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam int         IRQ_SHUT   = 0;
   localparam int         IRQ_RESUME = 1;
   localparam int         DLY_W      = 7;
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0] output_config;
      logic [3:0] module_mode_select;
   } prds_mode_t;
   typedef struct packed {
      logic       shutdown_event_status;
      logic [2:0] shutdown_source_select;
      logic [1:0] shutdown_state_pair_ac;
      logic [1:0] shutdown_state_pair_bd;
   } prds_shut_t;
   typedef struct packed {
      logic             auto_restart_enable;
      logic [DLY_W-1:0] activation_delay_count;
   } prds_dly_t;
   typedef struct packed {
      logic       steer_sync;
      logic [3:0] steer_enable;
   } prds_steer_t;
   typedef struct packed {
      logic [3:0] drive;
      logic [3:0] oe;
   } prds_pin_t;
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SHUT,
      ST_RESUME
   } prds_state_t;
endpackage : prds_pkg

// >>> verilog/prds_top.sv
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
// How it works
// - with auto restart on, the flag clears once the trip cause is gone.
// - auto restart off keeps pins shut until software clears the flag.
// - each rise to active is held back by the 7-bit delay count in cycles.
// - with sync set, steering waits for the period start, else next cycle.
// - a steered pin carries the waveform with mode-select polarity.
// - a pin with its steering enable clear is handed back to the port.
// - steering enables act only in pwm mode with single-output configuration.
// - bits 7 to 5 of the steering register read zero and ignore writes.
// - a selected trip source sets the flag and pins hold shutdown while set.
// - source select picks comparator one/two high or fault low; 000 none.
// - in shutdown pairs a/c and b/d drive 0 for 00, 1 for 01, off for 1x.
// - mode-select bit 1 inverts pins a and c, bit 0 inverts pins b and d.
module prds_top
   import prds_pkg::*;
(
   input  wire logic                      clk_in,
   input  wire logic                      nrst_in,
   input  wire logic [prds_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                      avs_read_in,
   input  wire logic                      avs_write_in,
   input  wire logic [31:0]               avs_writedata_in,
   input  wire logic [3:0]                avs_byteenable_in,
   output logic      [31:0]               avs_readdata_out,
   output logic                           avs_waitrequest_out,
   input  wire logic                      pwm_raw_in,
   input  wire logic                      period_start_in,
   input  wire logic                      comparator_one_output_in,
   input  wire logic                      comparator_two_output_in,
   input  wire logic                      fault_input_in,
   input  wire prds_pkg::prds_pin_t       port_pins_in,
   output prds_pkg::prds_pin_t            pwm_pins_out,
   output logic                           irq_out
);
   import prds_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // register state
   prds_mode_t  mode_q;
   prds_shut_t  shut_q;
   prds_dly_t   dly_q;
   prds_steer_t steer_q;
   logic [3:0]  applied_q;
   logic [1:0]  stat_q;
   logic [1:0]  mask_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   prds_state_t state_q;
   logic        flag_d;
   prds_state_t state_d;

   ////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then the access completes
   wire req     = avs_read_in | avs_write_in;
   wire wr_fire = avs_write_in & ack_q & avs_byteenable_in[0];
   wire [7:0] wb = avs_writedata_in[7:0];
   wire wr_mode  = wr_fire & (avs_address_in == OFS_MODE);
   wire wr_shut  = wr_fire & (avs_address_in == OFS_SHUT);
   wire wr_dly   = wr_fire & (avs_address_in == OFS_DLY);
   wire wr_steer = wr_fire & (avs_address_in == OFS_STEER);
   wire wr_stat  = wr_fire & (avs_address_in == OFS_IRQ_STAT);
   wire wr_mask  = wr_fire & (avs_address_in == OFS_IRQ_MASK);

   assign avs_waitrequest_out = req & ~ack_q;
   assign avs_readdata_out    = rdata_q;

   // read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      case (avs_address_in)
         OFS_MODE:     rd_mux = {mode_q.output_config, 2'h0,
                                 mode_q.module_mode_select};
         OFS_SHUT:     rd_mux = shut_q;
         OFS_DLY:      rd_mux = dly_q;
         OFS_STEER:    rd_mux = {3'h0, steer_q};
         OFS_IRQ_STAT: rd_mux = {6'h0, stat_q};
         OFS_IRQ_MASK: rd_mux = {6'h0, mask_q};
         OFS_STATUS:   rd_mux = {3'h0, state_q != ST_RUN, applied_q};
         default:      rd_mux = 8'h00;
      endcase
   end

   // read data is caught in the wait cycle and held until the next read
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q <= req & ~ack_q;
         if (avs_read_in & ~ack_q)
            rdata_q <= {24'h0, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q  <= RST_MODE;
         dly_q   <= RST_DLY;
         steer_q <= RST_STEER;
         mask_q  <= RST_IRQ;
      end else begin
         if (wr_mode)
            mode_q <= {wb[7:6], wb[3:0]};
         if (wr_dly)
            dly_q <= wb;
         if (wr_steer)
            steer_q <= wb[4:0]; // upper bits dropped
         if (wr_mask)
            mask_q <= wb[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // trip sources: bit 0 comparator one, bit 1 comparator two,
   // bit 2 fault pin low; code 000 selects nothing
   wire [2:0] src = {~fault_input_in, comparator_two_output_in,
                     comparator_one_output_in};
   wire trip = |(shut_q.shutdown_source_select & src);

   // shutdown flag: a trip always wins over any clear
   always_comb begin
      flag_d = shut_q.shutdown_event_status;
      if (trip)
         flag_d = 1'b1;
      else if (wr_shut)
         flag_d = wb[7];
      else if (dly_q.auto_restart_enable)
         flag_d = 1'b0;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shut_q <= RST_SHUT;
      end else begin
         shut_q.shutdown_event_status <= flag_d;
         if (wr_shut)
            shut_q[6:0] <= wb[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // restart sequencing: once the flag clears, waveform comes back at
   // the next period start so no runt pulse reaches the bridge
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
            if (shut_q.shutdown_event_status)
               state_d = ST_SHUT;
         ST_SHUT:
            if (!shut_q.shutdown_event_status)
               state_d = ST_RESUME;
         ST_RESUME:
            if (shut_q.shutdown_event_status)
               state_d = ST_SHUT;
            else if (period_start_in)
               state_d = ST_RUN;
         default:
            state_d = ST_SHUT;
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   // shutdown takes effect with the flag, without waiting for the fsm
   wire shut_act = shut_q.shutdown_event_status
                 | (state_q != ST_RUN);

   ////////////////////////////////////////////////////////////////////
   // interrupt status: sticky, write one to clear, set wins
   wire [1:0] ev;
   assign ev[IRQ_SHUT]   = flag_d & ~shut_q.shutdown_event_status;
   assign ev[IRQ_RESUME] = (state_q == ST_RESUME) & (state_d == ST_RUN);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         stat_q <= RST_IRQ;
      else
         stat_q <= ev | (stat_q & ~({2{wr_stat}} & wb[1:0]));
   end

   assign irq_out = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////
   // activation delay: rises wait out the count, falls pass at once
   logic             raw_q;
   logic             act_q;
   logic [DLY_W-1:0] cnt_q;
   wire raw_rise = pwm_raw_in & ~raw_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         raw_q <= 1'b0;
         act_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         raw_q <= pwm_raw_in;
         if (!pwm_raw_in) begin
            act_q <= 1'b0;
            cnt_q <= '0;
         end else if (raw_rise) begin
            // zero count goes active with no extra cycles
            act_q <= (dly_q.activation_delay_count == '0);
            cnt_q <= dly_q.activation_delay_count;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
            act_q <= (cnt_q == 7'h01);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // steering update: immediate or at period start
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         applied_q <= RST_STEER[3:0];
      else if (!steer_q.steer_sync || period_start_in)
         applied_q <= steer_q.steer_enable;
   end

   wire pwm_mode   = mode_q.module_mode_select[3:2] == MODE_PWM;
   wire steer_mode = pwm_mode
                   & (mode_q.output_config == CFG_SINGLE);
   // outside steering the enables are ignored; pwm mode modulates pin a
   // alone, other modes modulate none; bridge modes belong to another block
   wire [3:0] pin_en = !pwm_mode  ? 4'h0
                     : steer_mode ? applied_q
                     :              4'h1;

   ////////////////////////////////////////////////////////////////////
   // pin drivers, registered so the pads see no decode glitches
   prds_pin_t pin_d;
   prds_pin_t pin_q;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         // a and c share polarity and shutdown state, b and d likewise
         wire       pol = (gi % 2 == 0) ? mode_q.module_mode_select[1]
                                        : mode_q.module_mode_select[0];
         wire [1:0] pss = (gi % 2 == 0) ? shut_q.shutdown_state_pair_ac
                                        : shut_q.shutdown_state_pair_bd;
         always_comb begin
            if (!pin_en[gi]) begin
               pin_d.drive[gi] = port_pins_in.drive[gi];
               pin_d.oe[gi]    = port_pins_in.oe[gi];
            end else if (shut_act) begin
               pin_d.drive[gi] = pss[0] & ~pss[1];
               pin_d.oe[gi]    = ~pss[1];
            end else begin
               pin_d.drive[gi] = act_q ^ pol;
               pin_d.oe[gi]    = 1'b1;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         pin_q <= '0;
      else
         pin_q <= pin_d;
   end

   assign pwm_pins_out = pin_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // cycles the raw waveform has been high, for the delay check
   logic [7:0] hi_q;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         hi_q <= 8'h0;
      else if (!pwm_raw_in)
         hi_q <= 8'h0;
      else if (hi_q != 8'hff)
         hi_q <= hi_q + 8'h01;
   end

   property p_auto_clear;
      shut_q.shutdown_event_status && dly_q.auto_restart_enable
         && !trip && !wr_shut |=> !shut_q.shutdown_event_status;
   endproperty
   a_auto_clear: assert property (p_auto_clear)
      else $error("flag did not clear after cause went away");

   property p_manual_hold;
      shut_q.shutdown_event_status && !dly_q.auto_restart_enable
         && !wr_shut |=> shut_q.shutdown_event_status;
   endproperty
   a_manual_hold: assert property (p_manual_hold)
      else $error("flag cleared without software");

   property p_delay;
      $rose(act_q) && $stable(dly_q.activation_delay_count)
         |-> hi_q == {1'b0, dly_q.activation_delay_count} + 8'h01;
   endproperty
   a_delay: assert property (p_delay)
      else $error("activation delay count not honoured");

   property p_sync_defer;
      steer_q.steer_sync && !period_start_in |=> $stable(applied_q);
   endproperty
   a_sync_defer: assert property (p_sync_defer)
      else $error("steering changed inside a period");

   property p_sync_now;
      !steer_q.steer_sync |=> applied_q == $past(steer_q.steer_enable);
   endproperty
   a_sync_now: assert property (p_sync_now)
      else $error("steering not applied on next cycle");

   property p_release;
      !pin_en[2] |=> pwm_pins_out.drive[2] == $past(port_pins_in.drive[2])
         && pwm_pins_out.oe[2] == $past(port_pins_in.oe[2]);
   endproperty
   a_release: assert property (p_release)
      else $error("disabled pin not handed to port");

   property p_nonsteer;
      !steer_mode |=> pwm_pins_out.drive[3] == $past(port_pins_in.drive[3])
         && pwm_pins_out.oe[3] == $past(port_pins_in.oe[3]);
   endproperty
   a_nonsteer: assert property (p_nonsteer)
      else $error("steering active outside single output");

   property p_unimpl;
      avs_read_in && !avs_waitrequest_out
         && avs_address_in == OFS_STEER |-> avs_readdata_out[7:5] == 3'h0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented steering bits read non-zero");

   property p_trip;
      trip |=> shut_q.shutdown_event_status ##1 !pwm_pins_out.oe[0]
         || pwm_pins_out.drive[0]
            == (shut_q.shutdown_state_pair_ac == 2'h1)
         || !pin_en[0];
   endproperty
   a_trip: assert property (p_trip)
      else $error("trip did not force shutdown");

   property p_pair_bd;
      shut_act && pin_en[1] && shut_q.shutdown_state_pair_bd[1]
         |=> !pwm_pins_out.oe[1];
   endproperty
   a_pair_bd: assert property (p_pair_bd)
      else $error("b pin not released in shutdown");

   property p_polarity;
      !shut_act && pin_en[0] |=> pwm_pins_out.oe[0]
         && pwm_pins_out.drive[0]
            == ($past(act_q) ^ $past(mode_q.module_mode_select[1]));
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("pin a polarity wrong");

endmodule : prds_top

// >>> tb/prds_driver_model.sv
`timescale 1ns/1ps
module prds_driver_model
   import prds_pkg::*;
(
   input  wire logic                clk_in,
   input  wire prds_pkg::prds_pin_t pins_in,
   input  wire logic                trip_req_in,
   output logic                     fault_input_out,
   output logic [3:0]               gate_out
);
   logic fault_q = 1'b1;
   // bridge gate inputs carry pull-downs, so a released pin reads low
   assign gate_out = pins_in.oe & pins_in.drive;
   // desaturation detect pulls the fault line low, one cycle late
   always @(posedge clk_in) begin
      fault_q <= !trip_req_in;
   end
   assign fault_input_out = fault_q;
endmodule : prds_driver_model

// >>> tb/tb_prds_pwm_restart_delay_steering.sv
`timescale 1ns/1ps
module tb_pwm_restart_delay_steering;
   import prds_pkg::*;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] steer;
      logic       raw;
      prds_pin_t  port;
      prds_pin_t  exp;
   } prds_row_t;
   logic        clk_in = 1'b0, nrst_in = 1'b0;
   logic [4:0]  avs_address_in = '0;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
   logic [3:0]  avs_byteenable_in = '0, gate;
   logic        avs_waitrequest_out, irq_out, fault_n;
   logic        pwm_raw_in = 1'b0, period_start_in = 1'b0, trip = 1'b0;
   logic        comparator_one_output_in = 1'b0;
   logic        comparator_two_output_in = 1'b0;
   prds_pin_t   port_pins_in = '0, pwm_pins_out;
   int          mismatches = 0, checks_done = 0, up0, dn0, up, dn;
   logic [2:0]  cc;
   prds_row_t   rows [9] = '{
      '{8'h0c, 8'h0f, 1'b1, 8'h00, 8'hff}, // all steered, active high
      '{8'h0e, 8'h0f, 1'b1, 8'h00, 8'haf}, // a/c inverted
      '{8'h0d, 8'h0f, 1'b1, 8'h00, 8'h5f}, // b/d inverted
      '{8'h0f, 8'h0f, 1'b0, 8'h00, 8'hff}, // all inverted, idle
      '{8'h0c, 8'h05, 1'b1, 8'h28, 8'h7d}, // b/d back to port
      '{8'h0c, 8'h00, 1'b1, 8'h96, 8'h96}, // nothing steered
      '{8'h08, 8'h0f, 1'b1, 8'h96, 8'h96}, // compare mode
      '{8'h00, 8'h0f, 1'b1, 8'h3c, 8'h3c}, // unit off
      '{8'h4c, 8'h0f, 1'b1, 8'h86, 8'h97}};// not single: pin a only
   // registers that read zero straight after reset, last one unmapped
   logic [4:0]  zero_regs [6] = '{OFS_MODE, OFS_SHUT, OFS_DLY,
                                  OFS_IRQ_STAT, OFS_IRQ_MASK, 5'h1c};
   always #2.5 clk_in = ~clk_in;
   prds_top dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .pwm_raw_in(pwm_raw_in),
      .period_start_in(period_start_in),
      .comparator_one_output_in(comparator_one_output_in),
      .comparator_two_output_in(comparator_two_output_in),
      .fault_input_in(fault_n), .port_pins_in(port_pins_in),
      .pwm_pins_out(pwm_pins_out), .irq_out(irq_out));
   prds_driver_model drv (.clk_in(clk_in), .pins_in(pwm_pins_out),
      .trip_req_in(trip), .fault_input_out(fault_n), .gate_out(gate));
   ////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic timeout();
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      finish_test();
   endtask : timeout
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   // pins are sampled mid-cycle so registered updates have landed
   task automatic chk_pins(input prds_pin_t exp);
      @(negedge clk_in);
      checks_done++;
      if (pwm_pins_out !== exp) begin
         mismatches++;
         $display("[FAIL] %0t pins %h expected %h", $time, pwm_pins_out, exp);
      end
      @(posedge clk_in);
   endtask : chk_pins
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   // one avalon transfer; called and left on a rising edge
   task automatic bus(input logic we, input logic [4:0] a,
                      input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address_in    <= a;
      avs_writedata_in  <= {24'h0, d};
      avs_byteenable_in <= be;
      avs_write_in      <= we;
      avs_read_in       <= !we;
      // waitrequest and read data are judged at the rising edge only
      do begin
         @(posedge clk_in);
         n++;
         if (n > 20) timeout();
      end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
      @(posedge clk_in); // keeps strobes from being driven twice at one edge
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask : wr
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 8'h00, 4'h0);
   endtask : rd
   task automatic do_reset();
      nrst_in <= 1'b0;
      cyc(2);
      chk_pins(8'h00); // released in reset
      cyc(6);
      nrst_in <= 1'b1;
      @(posedge clk_in);
   endtask : do_reset
   task automatic pulse();
      period_start_in <= 1'b1;
      @(posedge clk_in);
      period_start_in <= 1'b0;
      @(posedge clk_in);
   endtask : pulse
   task automatic set_src(input int s, input logic v);
      if (s == 0) comparator_one_output_in <= v;
      if (s == 1) comparator_two_output_in <= v;
      if (s == 2) trip <= v;
   endtask : set_src
   // cycles until pin a reaches the given level
   task automatic wait_a(input logic v, output int c);
      c = 0;
      @(negedge clk_in);
      while (pwm_pins_out.drive[0] !== v) begin
         c++;
         if (c > 300) timeout();
         @(negedge clk_in);
      end
      @(posedge clk_in);
   endtask : wait_a
   task automatic rise_fall(input logic [7:0] d, output int u, output int f);
      wr(OFS_DLY, d);
      pwm_raw_in <= 1'b1;
      wait_a(1'b1, u);
      pwm_raw_in <= 1'b0;
      wait_a(1'b0, f);
   endtask : rise_fall
   ////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      foreach (rows[i]) begin
         wr(OFS_MODE, rows[i].mode);
         wr(OFS_STEER, rows[i].steer);
         pwm_raw_in   <= rows[i].raw;
         port_pins_in <= rows[i].port;
         cyc(4);
         chk_pins(rows[i].exp);
      end
      $display("steering table done");
      // activation delay, boundary counts; the fall is never delayed
      port_pins_in <= '0;
      pwm_raw_in   <= 1'b0;
      wr(OFS_MODE, 8'h0c);
      wr(OFS_STEER, 8'h01);
      rise_fall(8'h00, up0, dn0);
      for (int k = 0; k < 2; k++) begin
         rise_fall(8'(k == 0 ? 1 : 127), up, dn);
         chk_reg(32'(up - up0), (k == 0) ? 32'h1 : 32'h7f);
         chk_reg(32'(dn), 32'(dn0));
      end
      $display("delay test done");
      // steering update held for the period start when sync is set
      wr(OFS_DLY, 8'h00);
      pwm_raw_in <= 1'b1;
      wr(OFS_STEER, 8'h12);
      rd(OFS_STATUS);
      chk_reg(q, 32'h01);
      chk_pins(8'h11);
      pulse();
      rd(OFS_STATUS);
      chk_reg(q, 32'h02);
      chk_pins(8'h22);
      wr(OFS_STEER, 8'h04);
      rd(OFS_STATUS);
      chk_reg(q, 32'h04);
      $display("sync test done");
      // every source code against each cause alone, manual restart
      for (int c = 0; c < 8; c++) begin
         for (int s = 0; s < 3; s++) begin
            cc = 3'(c);
            wr(OFS_SHUT, {1'b0, cc, 4'h0});
            set_src(s, 1'b1);
            cyc(4);
            rd(OFS_STATUS);
            chk_reg(q[4], cc[s]);
            set_src(s, 1'b0);
            cyc(4);
            rd(OFS_SHUT);
            chk_reg(q[7], cc[s]);
            wr(OFS_SHUT, {1'b0, cc, 4'h0});
            pulse();
         end
      end
      $display("source table done");
      // auto restart, shutdown pin states and the interrupt
      wr(OFS_STEER, 8'h0f);
      pwm_raw_in <= 1'b0;
      wr(OFS_DLY, 8'h80);
      wr(OFS_IRQ_STAT, 8'h03);
      wr(OFS_IRQ_MASK, 8'h01);
      wr(OFS_SHUT, 8'h16);
      comparator_one_output_in <= 1'b1;
      cyc(4);
      chk_pins(8'h55);
      @(negedge clk_in);
      chk_reg({28'h0, gate}, 32'h5);
      chk_reg({31'h0, irq_out}, 32'h1);
      @(posedge clk_in);
      comparator_one_output_in <= 1'b0;
      cyc(4);
      rd(OFS_SHUT);
      chk_reg(q, 32'h16);
      pulse();
      chk_pins(8'h0f);
      rd(OFS_IRQ_STAT);
      chk_reg(q, 32'h03);
      wr(OFS_IRQ_MASK, 8'h00);
      chk_reg({31'h0, irq_out}, 32'h0);
      wr(OFS_IRQ_STAT, 8'h01);
      rd(OFS_IRQ_STAT);
      chk_reg(q, 32'h02);
      // manual restart: pins stay tripped until software clears the flag
      wr(OFS_DLY, 8'h00);
      pwm_raw_in <= 1'b1;
      wr(OFS_SHUT, 8'h41);
      trip <= 1'b1;
      cyc(4);
      chk_pins(8'haf);
      trip <= 1'b0;
      cyc(4);
      pulse();
      chk_pins(8'haf);
      wr(OFS_SHUT, 8'h41);
      pulse();
      chk_pins(8'hff);
      $display("shutdown test done");
      // unused steering bits, masked write, unmapped place, reset values
      wr(OFS_STEER, 8'hff);
      rd(OFS_STEER);
      chk_reg(q, 32'h1f);
      bus(1'b1, OFS_DLY, 8'h55, 4'h0);
      rd(OFS_DLY);
      chk_reg(q, 32'h00);
      do_reset();
      foreach (zero_regs[k]) begin
         rd(zero_regs[k]);
         chk_reg(q, 32'h00);
      end
      rd(OFS_STEER);
      chk_reg(q, {24'h0, 3'h0, RST_STEER});
      $display("register test done");
      finish_test();
   end
endmodule : tb_pwm_restart_delay_steering
